/* File: dpd_param_defines.vh */
`ifndef DPD_PARAM_DEFINES_VH
`define DPD_PARAM_DEFINES_VH
`define PARAM_DWORD 32'h5cd5a2f7
`define PARAM_BYTE_BASE 8'h34
`define SUPPORT_BIT 31
`define ENTER_LSB 23
`define EXIT_LSB 15
`define UNIT_LSB 13
`define COUNT_LSB 8
`define RSV_HI_LSB 4
`define POLL_LSB 2
`define OP_ENTER 8'hb9
`define OP_EXIT 8'hab
`define OP_STATUS 8'h05
`define OP_PARAM 8'h5a
`define UNIT_NS 1000
`define CLK_NS 4
`define WAKE_NS ((2 + 1) * `UNIT_NS)
// 750 cycles of 4 ns make the 3us wake delay; sized to fit the 12-bit counter
`define WAKE_CYCLES 12'h2ee
`define RST_WAKE 12'h000
`define RST_BYTE 8'h00
`define RST_IGN 2'b00
`define RST_WORD 32'h00000000
`define ADDR_PARAM 8'h00
`define ADDR_CMD 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_RDATA 8'h0c
`define ADDR_BUSY 8'h10
`endif

/* File: dpd_param_busy.v */
`timescale 1ns/1ps
`default_nettype none
`include "dpd_param_defines.vh"
module dpd_param_busy (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  output reg sleeping,
  output wire operation_in_progress_flag
);
  // Parameter word and its four bytes
  wire [31:0] param;
  wire [7:0] param_byte [0:3];

  // Bus strobes
  wire access;
  wire wr;
  wire rd_setup;
  wire cmd_wr;
  wire busy_wr;
  wire [7:0] op;
  wire [1:0] byte_sel;

  // Opcode decode
  wire op_enter;
  wire op_exit;
  wire op_status;
  wire op_param;

  // Sleep, delay and refusal state
  wire wake_active;
  wire cmd_refused;
  wire cmd_accepted;
  reg busy_sw;
  reg next_busy_sw;
  reg [11:0] wake_cnt;
  reg [11:0] next_wake_cnt;
  reg next_sleeping;
  reg [7:0] rdata;
  reg [7:0] next_rdata;
  reg [1:0] cmd_ignored;
  reg [1:0] next_cmd_ignored;
  reg [31:0] status_word;
  reg [31:0] read_word;

  // Parameter word assembled from its fields; every bit is a constant,
  // so the word costs no flip-flops and cannot be disturbed by reset
  assign param[`SUPPORT_BIT] = 1'b0;
  assign param[30:`ENTER_LSB] = `OP_ENTER;
  assign param[22:`EXIT_LSB] = `OP_EXIT;
  assign param[14:`UNIT_LSB] = 2'b01;
  assign param[12:`COUNT_LSB] = 5'b00010;
  assign param[7:`RSV_HI_LSB] = 4'hf;
  assign param[3:`POLL_LSB] = 2'b01;
  assign param[1:0] = 2'b11;

  // One slice per parameter byte; slice 0 is the byte at relative address 34h
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_param_byte
      assign param_byte[gi] = param[gi*8 +: 8];
    end
  endgenerate

  // APB strobes; a write takes effect only at the access edge
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign cmd_wr = wr & (paddr == `ADDR_CMD);
  assign busy_wr = wr & (paddr == `ADDR_BUSY);
  assign op = pwdata[7:0];
  assign byte_sel = pwdata[9:8];

  // Zero wait states and never an error: every register answers at once
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Opcode decode from the low byte of the command write
  assign op_enter = (op == `OP_ENTER);
  assign op_exit = (op == `OP_EXIT);
  assign op_status = (op == `OP_STATUS);
  assign op_param = (op == `OP_PARAM);

  // While the delay runs nothing is taken; while asleep only the wake opcode.
  // Refusing instead of queueing keeps a host that ignores the delay from
  // stacking commands behind the wake-up.
  assign wake_active = (wake_cnt != `RST_WAKE);
  assign cmd_refused = cmd_wr & (wake_active | (sleeping & ~op_exit));
  assign cmd_accepted = cmd_wr & ~cmd_refused;

  // Busy while a software-started job runs or the wake delay counts down
  assign operation_in_progress_flag = busy_sw | wake_active;

  // State registers; all next values come from the processes below
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleeping <= 1'b0;
      wake_cnt <= `RST_WAKE;
      rdata <= `RST_BYTE;
      cmd_ignored <= `RST_IGN;
      busy_sw <= 1'b0;
    end else begin
      sleeping <= next_sleeping;
      wake_cnt <= next_wake_cnt;
      rdata <= next_rdata;
      cmd_ignored <= next_cmd_ignored;
      busy_sw <= next_busy_sw;
    end
  end

  // Software busy bit stands for an operation in progress
  always @* begin
    next_busy_sw = busy_sw;
    if (busy_wr) begin
      next_busy_sw = pwdata[0];
    end
  end

  // Wake delay counts down from the edge that takes the wake opcode;
  // the reload cannot meet a running count, since commands are refused then
  always @* begin
    next_wake_cnt = wake_cnt;
    if (wake_active) begin
      next_wake_cnt = wake_cnt - 12'h001;
    end
    if (cmd_accepted && sleeping && op_exit) begin
      next_wake_cnt = `WAKE_CYCLES;
    end
  end

  // Sleep is entered by its opcode and left only by the wake opcode
  always @* begin
    next_sleeping = sleeping;
    if (cmd_accepted) begin
      if (sleeping) begin
        next_sleeping = 1'b0;
      end else if (op_enter) begin
        next_sleeping = 1'b1;
      end
    end
  end

  // Refused commands are counted; the count wraps, so it only shows activity
  always @* begin
    next_cmd_ignored = cmd_ignored;
    if (cmd_refused) begin
      next_cmd_ignored = cmd_ignored + 2'b01;
    end
  end

  // Result byte of the last accepted status or parameter command;
  // other opcodes leave the previous result in place
  always @* begin
    next_rdata = rdata;
    if (cmd_accepted && !sleeping) begin
      case (op)
        `OP_STATUS: begin
          next_rdata = {7'h00, operation_in_progress_flag};
        end
        `OP_PARAM: begin
          next_rdata = param_byte[byte_sel];
        end
        default: begin
          next_rdata = rdata;
        end
      endcase
    end
  end

  // Status word: refusal count, sleep state, busy flag
  always @* begin
    status_word = {28'h0000000, cmd_ignored, sleeping, operation_in_progress_flag};
  end

  // Read mux for the register map; unmapped offsets read as zero, no error
  always @* begin
    case (paddr)
      `ADDR_PARAM: read_word = param;
      `ADDR_STATUS: read_word = status_word;
      `ADDR_RDATA: read_word = {24'h000000, rdata};
      `ADDR_BUSY: read_word = {31'h00000000, busy_sw};
      default: read_word = `RST_WORD;
    endcase
  end

  // Read data latched in the setup cycle so it stands through the access
  // phase; the cost is that a read shows state one cycle old
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RST_WORD;
    end else if (rd_setup) begin
      prdata <= read_word;
    end
  end

  // Note for integrators: the busy flag is a level and may change in any
  // cycle; sample it through the status register, not as a pulse.
  // The parameter word is fixed and needs no reset sequencing.
  // The refusal count is diagnostic only and wraps without warning.
endmodule // dpd_param_busy
`default_nettype wire

/* File: dpd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dpd_checker(input wire logic pclk, presetn, psel, penable, pwrite, input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, input wire logic pready, pslverr, input wire logic [31:0] prdata,
  input wire logic sleeping, operation_in_progress_flag);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Command write seen at the access edge
  wire cmd = psel && penable && pwrite && paddr == 8'h04;
  sequence wake_hold; (!sleeping && operation_in_progress_flag) [*8]; endsequence
  sequence status_setup; psel && !penable && !pwrite && paddr == 8'h08; endsequence
  chk_param_word: assert property (psel && !penable && !pwrite && paddr == 8'h00 |=> prdata == 32'h5cd5a2f7)
    else $error("parameter word wrong");
  chk_enter_sleep: assert property (cmd && pwdata[7:0] == 8'hb9 && !operation_in_progress_flag |=> sleeping)
    else $error("sleep not entered");
  chk_wake_delay: assert property (cmd && sleeping && pwdata[7:0] == 8'hab |=> wake_hold)
    else $error("wake or delay wrong");
  chk_ignore_asleep: assert property (cmd && sleeping && pwdata[7:0] != 8'hab |=> sleeping)
    else $error("command taken while asleep");
  chk_zero_wait: assert property (pready && !pslverr)
    else $error("bus answer wrong");
  chk_status_bits: assert property (status_setup |=> prdata[1:0] == $past({sleeping, operation_in_progress_flag}))
    else $error("status bits wrong");
endmodule // dpd_checker
bind dpd_param_busy dpd_checker u_dpd_checker(.*);
`default_nettype wire

/* File: host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model(input wire logic pclk, pready, output logic psel, penable, pwrite, output logic [7:0] paddr,
  output logic [31:0] pwdata);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Setup, then access held until pready; released only after that edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (!pready);
    psel <= 0; penable <= 0;
  endtask
endmodule // host_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, pready, pslverr, sleeping, busy, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q[$];
  int err_count = 0, total_checks = 0, cyc = 0;
  initial forever #2 pclk = ~pclk;
  host_model u_host_model(.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  dpd_param_busy u_dpd_param_busy(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .sleeping(sleeping),
    .operation_in_progress_flag(busy));
  task chk(input logic [31:0] s, e); total_checks++; if (s !== e) begin err_count++;
    $display("mismatch %0t %h %h", $time, s, e); end endtask
  task test_done; if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found"); $finish; endtask
  task rd(input logic [7:0] a, input logic [31:0] e); q.push_back(e); u_host_model.xfer(0, a, 0); endtask
  task wr(input logic [7:0] a, input logic [31:0] d); u_host_model.xfer(1, a, d); endtask
  // Watcher: oldest note against each read answer; cycle ceiling cuts a hang
  always @(posedge pclk) begin if (++cyc == 6000) begin err_count++; test_done; end
    if (psel && penable && !pwrite && pready) chk(prdata, q.pop_front()); end
  initial begin int k; void'($urandom(32'h30f34a60)); repeat (8) @(posedge pclk); presetn <= 1;
    rd(8'h00, 32'h5cd5a2f7);
    repeat (4) begin k = $urandom % 4; wr(8'h04, {22'h0, k[1:0], 8'h5a});
      rd(8'h0c, (32'h5cd5a2f7 >> (8 * k)) & 32'hff); end
    wr(8'h10, 1); rd(8'h10, 1); rd(8'h08, 1); wr(8'h04, 8'h05); rd(8'h0c, 1); wr(8'h10, 0); rd(8'h08, 0);
    wr(8'h04, 8'hb9); rd(8'h08, 2); wr(8'h04, 8'h05); rd(8'h08, 6);
    wr(8'h04, 8'hab); rd(8'h08, 5); wr(8'h04, 8'hb9); rd(8'h08, 9);
    repeat (750) @(posedge pclk); rd(8'h08, 8);
    test_done;
  end
endmodule // tb_top
`default_nettype wire
